//--- design/dq_spi_phases.v
// dual-quad serial flash interface phase sequencer
`include "dq_spi_defs.vh"
module dq_spi_phases #(
  parameter PU_CYCLES = `PU_CYCLES
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        sck,
  input  wire        cs_n,
  input  wire [7:0]  io_in,
  output reg  [7:0]  io_out,
  output reg  [7:0]  io_oe,
  input  wire [7:0]  cfg_wdata,
  input  wire        cfg_we,
  input  wire        train_en,
  input  wire [7:0]  train_pattern,
  output wire [7:0]  config_reg_one,
  output wire        quad_mode,
  output wire        hold_wp_active,
  output wire        ready,
  output wire [6:0]  phase,
  output reg  [7:0]  cmd_q,
  output reg  [31:0] addr_q,
  output reg         cmd_exec,
  output reg         cmd_ignored,
  output wire [7:0]  wr_data,
  output wire        wr_valid,
  input  wire        wr_ready,
  input  wire [7:0]  rd_data,
  input  wire        rd_valid,
  output reg         rd_ready
);
  ////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 7'b0000001;
  localparam S_CMD  = 7'b0000010;
  localparam S_ADDR = 7'b0000100;
  localparam S_MODE = 7'b0001000;
  localparam S_LAT  = 7'b0010000;
  localparam S_OUT  = 7'b0100000;
  localparam S_DIN  = 7'b1000000;

  wire sck_s, cs_s;
  wire [7:0] io_s;
  sync2 u_sck (.clk(clk), .resetn(resetn), .init(1'b0), .d(sck), .q(sck_s));
  sync2 u_cs  (.clk(clk), .resetn(resetn), .init(1'b0), .d(cs_n), .q(cs_s));
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_io
      sync2 u_io (.clk(clk), .resetn(resetn), .init(1'b0), .d(io_in[gi]), .q(io_s[gi]));
    end
  endgenerate

  reg        sck_q;
  reg [6:0]  st_q;
  reg [7:0]  cfg1_q;
  reg        new_q;
  reg [16:0] pu_q;
  reg [5:0]  bits_q;
  reg [4:0]  lat_q;
  reg [15:0] clks_q;
  reg        quad_q;
  reg        ddr_q;
  reg        sh_en_q;
  reg [7:0]  byte_q;
  reg        nib_q;
  reg        fin_q;
  wire rise = sck_s && !sck_q;
  wire fall = !sck_s && sck_q;
  wire cs_hi = cs_s;

  assign config_reg_one = cfg1_q;
  assign quad_mode      = cfg1_q[`CFG_QUAD_BIT];
  assign hold_wp_active = !cfg1_q[`CFG_QUAD_BIT];           // R4
  assign ready          = (pu_q == 17'd0);
  assign phase          = st_q;

  // latency cycles from the two-bit code, per read type
  function [4:0] lat_of;
    input [1:0] lc;
    input [7:0] cmd;
    begin
      case (cmd)
        `CMD_DDRQIOR: lat_of = 5'd5 + {3'd0, lc};
        `CMD_QIOR:    lat_of = (lc == 2'd3) ? 5'd0 : 5'd4 + {3'd0, lc};
        `CMD_QUAD_OUT_RD: lat_of = (lc == 2'd3) ? 5'd0 : 5'd8;
        default:      lat_of = 5'd0;
      endcase
    end
  endfunction
  wire [4:0] lat_n = lat_of(cfg1_q[`CFG_LC_HI:`CFG_LC_LO], cmd_q);  // R9
  wire is_mod = (cmd_q == `CMD_QUAD_PROG) || (cmd_q == `CMD_PP) || (cmd_q == `CMD_SE) ||
                (cmd_q == `CMD_WR_REGS) || (cmd_q == `CMD_BE);
  wire is_quad_cmd = (cmd_q == `CMD_QUAD_PROG) || (cmd_q == `CMD_QUAD_OUT_RD) ||
                     (cmd_q == `CMD_QIOR) || (cmd_q == `CMD_DDRQIOR);

  // program data into the fifo; in_ready is left open, so bytes that arrive while it is full are dropped
  data_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
    .clk(clk), .resetn(resetn), .flush(1'b0),
    .in_data(byte_q), .in_valid(fin_q), .in_ready(),
    .out_data(wr_data), .out_valid(wr_valid), .out_ready(wr_ready)
  );

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!resetn) begin
      sck_q       <= 1'b0;
      st_q        <= S_IDLE;
      cfg1_q      <= `CFG_RESET;                             // R20
      // loaded in reset so ready never blips high right after release
      pu_q        <= PU_CYCLES[16:0];
      new_q       <= 1'b0;
      bits_q      <= 6'd0;
      lat_q       <= 5'd0;
      clks_q      <= 16'd0;
      quad_q      <= 1'b0;
      ddr_q       <= 1'b0;
      sh_en_q     <= 1'b0;
      byte_q      <= 8'h00;
      nib_q       <= 1'b0;
      fin_q       <= 1'b0;
      cmd_q       <= 8'h00;
      addr_q      <= 32'h00000000;
      cmd_exec    <= 1'b0;
      cmd_ignored <= 1'b0;
      io_out      <= 8'h00;
      io_oe       <= 8'h00;
      rd_ready    <= 1'b0;
    end else begin
      sck_q       <= sck_s;
      cmd_exec    <= 1'b0;
      cmd_ignored <= 1'b0;
      fin_q       <= 1'b0;
      rd_ready    <= 1'b0;
      if (!sh_en_q) begin
        pu_q    <= PU_CYCLES[16:0];
        sh_en_q <= 1'b1;
      end else if (pu_q != 17'd0) begin
        pu_q <= pu_q - 17'd1;
      end
      if (cfg_we && st_q == S_IDLE) cfg1_q <= cfg_wdata;
      if (cs_hi || !ready || !sh_en_q) begin                 // R22 R24 R26
        // a frame may only start from a deselect seen while ready
        new_q  <= cs_hi && ready && sh_en_q;
        nib_q  <= 1'b0;
        if (st_q != S_IDLE && is_mod) begin
          if (clks_q[2:0] == 3'd0) cmd_exec <= 1'b1;         // R21
          else cmd_ignored <= 1'b1;                           // R21
        end
        st_q   <= S_IDLE;
        io_oe  <= 8'h00;
        clks_q <= 16'd0;
        bits_q <= 6'd0;
      end else begin
        if (rise) clks_q <= clks_q + 16'd1;
        case (st_q)
          S_IDLE: if (new_q) begin                            // R24
            st_q   <= S_CMD;
            bits_q <= 6'd0;
            new_q  <= 1'b0;
          end
          S_CMD: if (rise) begin
            cmd_q  <= {cmd_q[6:0], io_s[0]};                  // R23 R25
            bits_q <= bits_q + 6'd1;
            if (bits_q == 6'd7) begin
              bits_q <= 6'd0;
              addr_q <= 32'h00000000;
              st_q   <= S_ADDR;
            end
          end
          S_ADDR: begin
            if (bits_q == 6'd0 && !rise) begin
              quad_q <= (cmd_q == `CMD_QIOR) || (cmd_q == `CMD_DDRQIOR);
              ddr_q  <= (cmd_q == `CMD_DDRQIOR);
              // refused: idle until the host deselects
              if (is_quad_cmd && !quad_mode) st_q <= S_IDLE;  // R20
            end
            if (ddr_q && (rise || fall)) begin               // R15
              addr_q <= {addr_q[27:0], io_s[3:0]};
              bits_q <= bits_q + 6'd4;
            end else if (rise && quad_q) begin               // R6
              addr_q <= {addr_q[27:0], io_s[3:0]};
              bits_q <= bits_q + 6'd4;
            end else if (rise) begin                         // R3
              addr_q <= {addr_q[30:0], io_s[0]};
              bits_q <= bits_q + 6'd1;
            end
            if ((rise || (ddr_q && fall)) && bits_q + (quad_q ? 6'd4 : 6'd1) == `ADDR_BITS) begin
              bits_q <= 6'd0;
              lat_q  <= lat_n;
              if (cmd_q == `CMD_QUAD_PROG) st_q <= S_DIN;    // R5
              else if (quad_q) st_q <= S_MODE;
              else if (lat_n == 5'd0) st_q <= S_OUT;         // R5
              else st_q <= S_LAT;
            end
          end
          S_MODE: if (rise || (ddr_q && fall)) begin         // R6 R15
            bits_q <= bits_q + 6'd4;
            if (bits_q == 6'd4) begin
              bits_q <= 6'd0;
              if (lat_q == 5'd0) st_q <= S_OUT;              // R8
              else st_q <= S_LAT;
            end
          end
          S_LAT: begin
            io_oe <= 8'h00;                                   // R10 R16
            if (ddr_q && train_en && lat_q <= `TRAIN_CYCLES) begin
              io_oe  <= 8'hFF;                                // R17
              io_out <= {8{train_pattern[lat_q[2:0]]}};
            end
            if (fall) begin                                   // R11
              lat_q <= lat_q - 5'd1;
              if (lat_q == 5'd1) begin
                st_q     <= S_OUT;                            // R12
                rd_ready <= 1'b1;
              end
            end
          end
          S_OUT: begin
            // outside DDR data changes on the falling edge so the host samples on rising
            if (fall || (ddr_q && rise)) begin               // R19
              nib_q <= ~nib_q;
              if (cmd_q == `CMD_QUAD_OUT_RD || quad_q) begin // R13 R14
                io_oe  <= 8'hFF;
                io_out <= nib_q ? {rd_data[3:0], rd_data[3:0]} : {rd_data[7:4], rd_data[7:4]};
                if (nib_q) rd_ready <= rd_valid;
              end else begin                                  // R1 R2
                io_oe  <= 8'h22;
                io_out <= {2'b00, rd_data[7-bits_q[2:0]], 3'b000, rd_data[7-bits_q[2:0]], 1'b0};
                bits_q <= bits_q + 6'd1;
                if (bits_q[2:0] == 3'd7) rd_ready <= rd_valid;
              end
            end
          end
          S_DIN: if (rise) begin                              // R6 R7
            byte_q <= {byte_q[3:0], io_s[3:0]};
            nib_q  <= ~nib_q;
            if (nib_q) fin_q <= 1'b1;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // dq_spi_phases

//--- design/dq_spi_defs.vh
// constants for the dual-quad serial flash phase sequencer
// How it works
// R1: single output drives both serial outputs, serial inputs ignored.
// R2: single output repeats until chip select rises.
// R3: quad program and quad output read addresses ride only IO0 and IO4.
// R4: in quad mode hold and write-protect pin functions are disabled.
// R5: quad output read address goes to latency if nonzero, else output.
// R6: quad input moves four bits per cycle, address/mode or program data.
// R7: host raises chip select after program data; interface returns to standby.
// R8: quad I/O read address/mode goes to latency if configured, else output.
// R9: two-bit latency code sets mode and latency cycles per read type.
// R10: during quad latency the device neither samples nor drives IO.
// R11: host releases IO by the falling edge ending the last latency cycle.
// R12: after the final quad latency cycle go to quad output.
// R13: quad output returns eight bits per cycle over both quad groups; code puts the same nibble on both groups each edge.
// R14: quad output continues until chip select rises.
// R15: DDR address/mode: eight bits rising, four falling; DDR latency follows. Code takes four bits on each edge.
// R16: host drives no IO during DDR latency.
// R17: training pattern, when enabled, drives all IO in last four DDR latency cycles.
// R18: host keeps training pattern off below five latency cycles.
// R19: DDR quad output drives both edges until chip select rises.
// R20: quad enable bit gates quad commands; defaults to one.
// R21: modifying commands need clock count multiple of 8, else silently ignored.
// R22: no command accepted during power-on initialization.
// R23: commands start with 8-bit instruction, MSB first, on rising edges.
// R24: chip select high keeps interface in standby, inputs ignored.
// R25: host drives identical instruction, address and mode on both groups.
// R26: chip select rising aborts any phase, releases IO, returns to standby.
`ifndef DQ_SPI_DEFS_VH
`define DQ_SPI_DEFS_VH

`define CMD_READ        8'h03
`define CMD_QUAD_OUT_RD 8'h6B
`define CMD_QIOR        8'hEB
`define CMD_DDRQIOR     8'hED
`define CMD_QUAD_PROG   8'h32
`define CMD_PP          8'h02
`define CMD_SE          8'hD8
`define CMD_WR_REGS     8'h01
`define CMD_BE          8'h60
`define ADDR_BITS       6'd24
`define MODE_BITS       4'd8
`define CFG_LC_HI       7
`define CFG_LC_LO       6
`define CFG_QUAD_BIT    1
`define CFG_RESET       8'h02
`define PAT_RESET       8'h34
`define TRAIN_CYCLES    5'd4
`define PU_TIME_US      300
`define CLK_MHZ         100
`define PU_CYCLES       (`PU_TIME_US * `CLK_MHZ)

`endif

//--- design/sync2.v
// two-flop synchroniser for one level
module sync2 (
  input  wire clk,
  input  wire resetn,
  input  wire init,
  input  wire d,
  output reg  q
);
  reg meta_q;
  always @(posedge clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
  // init unused at reset: reset values are constants; level settles in two edges
  wire unused_init = init;
endmodule // sync2

//--- design/data_fifo.v
// synchronous fifo with valid/ready on both sides
module data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            empty = (wr_q == rd_q);
  wire            full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  wire            push  = in_valid && !full;
  wire            pop   = out_valid && out_ready;
  assign in_ready  = !full;
  assign out_valid = !empty;
  always @* begin
    out_data = mem[rd_q[AW-1:0]];
  end
  always @(posedge clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
  always @(posedge clk) begin
    if (!resetn || flush) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule // data_fifo

//--- test/dq_spi_phases_monitor.sv
// port assertions for the dual-quad phase sequencer
module dq_spi_phases_monitor (
  input wire       clk,
  input wire       resetn,
  input wire       cs_n,
  input wire [7:0] io_oe,
  input wire [7:0] config_reg_one,
  input wire       quad_mode,
  input wire       hold_wp_active,
  input wire       ready,
  input wire       cmd_exec,
  input wire       cmd_ignored
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_standby_quiet: assert property (cs_n [*6] |-> io_oe == 8'h00)
    else $error("io driven while deselected");
  a_abort_release: assert property ($rose(cs_n) |-> ##[1:6] io_oe == 8'h00)
    else $error("io not released after deselect");
  a_hold_wp_off: assert property (hold_wp_active == !quad_mode)
    else $error("hold and write protect active in quad mode");
  a_quad_bit: assert property (quad_mode == config_reg_one[1])
    else $error("quad mode differs from quad enable bit");
  a_oe_groups: assert property (io_oe inside {8'h00, 8'h22, 8'hFF})
    else $error("io enable outside the output groups");
  a_quad_gate: assert property (!quad_mode |-> io_oe != 8'hFF)
    else $error("quad drive with quad mode off");
  a_no_early_exec: assert property (!ready |-> !cmd_exec)
    else $error("command run before power-up done");
  a_exec_excl: assert property (!(cmd_exec && cmd_ignored))
    else $error("command both run and ignored");
  a_exec_at_end: assert property (cmd_exec |-> cs_n && $past(cs_n))
    else $error("command run before deselect");
  a_cfg_default: assert property ($rose(resetn) |-> config_reg_one == 8'h02)
    else $error("configuration reset value wrong");
  c_exec: cover property (cmd_exec);
  c_ignored: cover property (cmd_ignored);
  c_quad_out: cover property (io_oe == 8'hFF);
  c_single_out: cover property (io_oe == 8'h22);
endmodule // dq_spi_phases_monitor

bind dq_spi_phases dq_spi_phases_monitor u_dq_spi_phases_monitor (.clk(clk), .resetn(resetn), .cs_n(cs_n),
  .io_oe(io_oe), .config_reg_one(config_reg_one), .quad_mode(quad_mode), .hold_wp_active(hold_wp_active),
  .ready(ready), .cmd_exec(cmd_exec), .cmd_ignored(cmd_ignored));

//--- test/spi_host_model.sv
// host side of the link: serial clock, select and io drive
module spi_host_model (
  input  wire  [7:0] io_out,
  input  wire  [7:0] io_oe,
  output logic       sck,
  output logic       cs_n,
  output wire  [7:0] io_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] h_oe;
  logic [7:0] h_val;
  logic [7:0] junk;
  // no pulls on io: released lines show a moving pattern, never a stale value
  assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_val) | (~io_oe & ~h_oe & junk);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    h_oe = 8'h00;
    h_val = 8'h00;
    junk = 8'h5A;
    forever #7 junk = ~junk;
  end
  // clock runs only inside the frame; na single-line bits, nq quad nibbles, nr released
  task automatic frame(input logic [7:0] c, input logic [23:0] a, input int na, nq, nr, input logic [7:0] b);
    int i;
    logic [7:0] d;
    cs_n = 1'b0;
    for (i = 0; i < 8 + na + nq + nr; i++) begin
      d = b + 8'(3 * ((i - 8 - na) / 2));
      h_oe = i < 8 + na ? 8'h11 : i < 8 + na + nq ? 8'hFF : 8'h00;
      h_val = i < 8 ? {8{c[7 - i]}} : i < 8 + na ? {8{a[31 - i]}} : {2{(i - 8 - na) % 2 ? d[3:0] : d[7:4]}};
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    h_oe = 8'h00;
    #60 cs_n = 1'b1;
    #250;
  endtask
endmodule // spi_host_model

//--- test/tb_dq_spi_phases.sv
// self-checking bench for the dual-quad phase sequencer
module tb_dq_spi_phases;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PU = 600;
  logic        clk, resetn, cfg_we, train_en, wr_ready, rd_valid;
  logic [7:0]  cfg_wdata, train_pattern, rd_data, seen_oe, b;
  logic [23:0] a;
  wire         sck, cs_n, quad_mode, hold_wp_active, ready, cmd_exec, cmd_ignored, wr_valid, rd_ready;
  wire  [7:0]  io_in, io_out, io_oe, config_reg_one, cmd_q, wr_data;
  wire  [6:0]  phase;
  wire  [31:0] addr_q;
  int          errors, n_tests, n_exec, n_ign, i, k;
  logic [7:0]  mod_op [3] = '{8'h01, 8'hD8, 8'h60};
  int          mod_na [3] = '{8, 24, 0};
  logic [7:0]  q_op [4] = '{8'h6B, 8'hEB, 8'hED, 8'h6B};
  dq_spi_phases #(.PU_CYCLES(PU)) u_dq_spi_phases (.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
    .train_en(train_en), .train_pattern(train_pattern), .config_reg_one(config_reg_one),
    .quad_mode(quad_mode), .hold_wp_active(hold_wp_active), .ready(ready), .phase(phase), .cmd_q(cmd_q),
    .addr_q(addr_q), .cmd_exec(cmd_exec), .cmd_ignored(cmd_ignored), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
  spi_host_model u_spi_host_model (.io_out(io_out), .io_oe(io_oe), .sck(sck), .cs_n(cs_n), .io_in(io_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    seen_oe = seen_oe | io_oe;
    if (cmd_exec === 1'b1) n_exec++;
    if (cmd_ignored === 1'b1) n_ign++;
    if (rd_ready === 1'b1) rd_data <= 8'($urandom);
  end
  ////////////////////////////////////////
  function automatic logic [7:0] pbyte(input logic [7:0] base, input int n);
    return base + 8'(3 * n);
  endfunction
  function automatic logic whole(input int n);
    return n % 8 == 0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] v);
    @(posedge clk);
    #1 cfg_wdata = v;
    cfg_we = 1'b1;
    @(posedge clk);
    #1 cfg_we = 1'b0;
  endtask
  // one frame with fresh address and data; enables drop some 3 clk after deselect
  task automatic go(input logic [7:0] c, input int na, input int nq, input int nr);
    a = 24'($urandom);
    b = 8'($urandom);
    seen_oe = 8'h00;
    n_exec = 0;
    n_ign = 0;
    u_spi_host_model.frame(c, a, na, nq, nr, b);
    repeat (8) @(posedge clk);
    #1;
  endtask
  initial begin
    void'($urandom(32'h543032d4));
    {resetn, cfg_we, train_en, wr_ready, rd_valid} = 5'h01;
    cfg_wdata = 8'h00;
    train_pattern = 8'($urandom);
    rd_data = 8'($urandom);
    {errors, n_tests, n_exec, n_ign} = 0;
    seen_oe = 8'h00;
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    chk("config_reg_one", 8'h02, config_reg_one);
    chk("ready", 0, ready);
    go(8'h01, 8, 0, 0);
    chk("early exec", 0, n_exec);
    for (k = 0; k < 2000 && ready !== 1'b1; k++) @(posedge clk);
    chk("ready", 1, ready);
    for (i = 0; i < 6; i++) begin
      k = mod_na[i % 3] + (i > 2 ? 3 : 0);
      go(mod_op[i % 3], k, 0, 0);
      chk("cmd_q", mod_op[i % 3], cmd_q);
      chk("cmd_exec", whole(8 + k), n_exec);
      chk("cmd_ignored", !whole(8 + k), n_ign);
    end
    cfg(8'h02);
    go(8'h03, 24, 0, 16);
    chk("single oe", 8'h22, seen_oe);
    chk("addr_q", a, addr_q[23:0]);
    for (i = 0; i < 4; i++) begin
      cfg({2'($urandom), 4'h0, i < 3, 1'b0});
      train_en = i == 2;
      go(q_op[i], i % 3 == 0 ? 24 : 0, i == 2 ? 4 : i % 3 == 0 ? 0 : 8, 24);
      chk("quad oe", i < 3 ? 8'hFF : 8'h00, seen_oe);
      if (i == 0) chk("quad addr", a, addr_q[23:0]);
    end
    cfg(8'h02);
    train_en = 1'b0;
    go(8'h32, 24, 36, 0);
    wr_ready = 1'b1;
    k = 0;
    // look at the head before the edge that pops it
    for (i = 0; i < 100 && k < 17; i++) begin
      if (wr_valid === 1'b1) begin
        chk("wr_data", pbyte(b, k), wr_data);
        k++;
      end
      @(posedge clk);
      #1;
    end
    chk("program bytes", 16, k);
    chk("fifo empty", 0, wr_valid);
    finish_test();
  end
endmodule // tb_dq_spi_phases
